// ===== verilog/scs_map.vh
// Constants for the start-up configuration sequencer: device addresses, values, timing.
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
// ****************************************************************
// Device register addresses and values written at start-up
// ****************************************************************
`define SCS_A_PORT_CFG    13'h000
`define SCS_V_PORT_RESET  8'h3c
`define SCS_V_PORT_DEF    8'h18
`define SCS_A_SPEED       13'h002
`define SCS_V_SPEED       8'h00
`define SCS_A_UPDATE      13'h0ff
`define SCS_V_UPDATE      8'h01
`define SCS_A_INDEX_2     13'h004
`define SCS_V_INDEX_2     8'h0f
`define SCS_A_INDEX_1     13'h005
`define SCS_V_INDEX_1     8'h3f
`define SCS_A_DECIM       13'h113
`define SCS_V_DECIM       8'h00
`define SCS_A_GAIN        13'h011
`define SCS_V_GAIN        8'h06
`define SCS_A_PROF0       13'hf00
`define SCS_A_PROF1       13'hf01
`define SCS_A_PROF2       13'hf02
`define SCS_A_PROF3       13'hf03
`define SCS_V_PROF0       8'hff
`define SCS_V_PROF1       8'h7f
`define SCS_V_PROF2       8'h00
`define SCS_V_PROF3       8'h80
`define SCS_A_PROF_IDX    13'h10c
`define SCS_V_PROF_IDX    8'h00
`define SCS_A_OUT_FMT     13'h014
`define SCS_V_OUT_FMT     8'h00
`define SCS_A_GLOBAL      13'h008
`define SCS_V_GLOBAL      8'h00
`define SCS_A_LINK_MODE   13'h021
`define SCS_V_LINK_MODE   8'h05
`define SCS_A_CLK_RATE    13'h199
`define SCS_V_CLK_RATE    8'h80
`define SCS_A_SER_FMT     13'h19b
`define SCS_V_SER_FMT     8'h50
`define SCS_A_START_EN    13'h188
`define SCS_V_START_EN    8'h01
`define SCS_A_START_MSB   13'h18b
`define SCS_V_START_MSB   8'h27
`define SCS_A_START_LSB   13'h18c
`define SCS_V_START_LSB   8'h72
`define SCS_A_PLL         13'h182
`define SCS_V_PLL         8'h82
`define SCS_V_SW_TRIG     8'h20
`define SCS_A_LPF         13'h00f
`define SCS_V_LPF         8'h18
`define SCS_A_AFILT       13'h02b
`define SCS_V_AFILT       8'h40
`define SCS_STEPS         6'd27
// ****************************************************************
// APB register map of the sequencer itself
// ****************************************************************
`define SCS_R_CTRL        12'h000
`define SCS_R_STATUS      12'h004
`define SCS_R_WAKE        12'h008
`define SCS_R_TUNE        12'h00c
`define SCS_CTRL_START    0
`define SCS_CTRL_HWTRIG   1
// ****************************************************************
// Timing
// ****************************************************************
`define SCS_CLK_MHZ       250
`define SCS_WAKE_US       375
`define SCS_WAKE_CYC      (`SCS_WAKE_US * `SCS_CLK_MHZ)
`define SCS_TUNE_ADC_CYC  10'd512
`define SCS_SCLK_DIV      5
`endif

// ===== verilog/scs_startup_config_sequencer.v
// Host-side sequencer that programs the receive front end over its three-wire serial port.
// What this block does
// - Profile entry zero, four bytes, is written before anything profile-related.
// - After the speed-mode write, host writes 0x01 to the update register.
// - Host writes 0x0F and 0x3F to the channel index registers.
// - Host writes 0x00 to the decimator control register.
// - Profile entry zero bytes are 0xFF, 0x7F, 0x00, 0x80.
// - After profile memory writes, host writes the profile index register.
// - One extra MSB-first write follows the profile index to finish the update.
// - After leaving power-down, host waits 375 microseconds before relying on output.
// - Host writes 0x05 to the output link mode register.
// - Host writes 0x80 to clock-rate and 0x82 to PLL control.
// - Each frame is a 16-bit instruction then one data byte.
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"
module scs_startup_config_sequencer #(
  parameter WAKE_CYC = `SCS_WAKE_CYC,
  parameter SCLK_DIV = `SCS_SCLK_DIV
) (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // ADC sample clock from the board, used to count tuning cycles.
  input  wire        adc_clk,
  // Serial control port toward the device.
  output reg         sclk_ff,
  output reg         select_bar_ff,
  output reg         sdio_out_ff,
  output reg         sdio_oe_ff,
  input  wire        sdio_in,
  // Hardware trigger toward the device.
  output reg         transmit_trigger_input_ff
);
  // ****************************************************************
  // State machine codes
  // ****************************************************************
  localparam ST_IDLE  = 5'b00001;
  localparam ST_SHIFT = 5'b00010;
  localparam ST_GAP   = 5'b00100;
  localparam ST_WAIT  = 5'b01000;
  localparam ST_DONE  = 5'b10000;
  // Ordered start-up table: address, value, and which wait follows.
  function [22:0] step_entry;
    input [5:0] idx;
    begin
      case (idx)
        6'd0:  step_entry = {2'd0, `SCS_A_PORT_CFG,  `SCS_V_PORT_RESET};
        6'd1:  step_entry = {2'd0, `SCS_A_SPEED,     `SCS_V_SPEED};
        6'd2:  step_entry = {2'd0, `SCS_A_UPDATE,    `SCS_V_UPDATE};
        6'd3:  step_entry = {2'd0, `SCS_A_INDEX_2,   `SCS_V_INDEX_2};
        6'd4:  step_entry = {2'd0, `SCS_A_INDEX_1,   `SCS_V_INDEX_1};
        6'd5:  step_entry = {2'd0, `SCS_A_DECIM,     `SCS_V_DECIM};
        6'd6:  step_entry = {2'd0, `SCS_A_GAIN,      `SCS_V_GAIN};
        6'd7:  step_entry = {2'd0, `SCS_A_PROF0,     `SCS_V_PROF0};
        6'd8:  step_entry = {2'd0, `SCS_A_PROF1,     `SCS_V_PROF1};
        6'd9:  step_entry = {2'd0, `SCS_A_PROF2,     `SCS_V_PROF2};
        6'd10: step_entry = {2'd0, `SCS_A_PROF3,     `SCS_V_PROF3};
        6'd11: step_entry = {2'd0, `SCS_A_PROF_IDX,  `SCS_V_PROF_IDX};
        6'd12: step_entry = {2'd0, `SCS_A_OUT_FMT,   `SCS_V_OUT_FMT};
        6'd13: step_entry = {2'd1, `SCS_A_GLOBAL,    `SCS_V_GLOBAL};
        6'd14: step_entry = {2'd0, `SCS_A_LINK_MODE, `SCS_V_LINK_MODE};
        6'd15: step_entry = {2'd0, `SCS_A_CLK_RATE,  `SCS_V_CLK_RATE};
        6'd16: step_entry = {2'd0, `SCS_A_SER_FMT,   `SCS_V_SER_FMT};
        6'd17: step_entry = {2'd0, `SCS_A_START_EN,  `SCS_V_START_EN};
        6'd18: step_entry = {2'd0, `SCS_A_START_MSB, `SCS_V_START_MSB};
        6'd19: step_entry = {2'd0, `SCS_A_START_LSB, `SCS_V_START_LSB};
        6'd20: step_entry = {2'd0, `SCS_A_PLL,       `SCS_V_PLL};
        6'd21: step_entry = {2'd0, `SCS_A_PROF_IDX,  `SCS_V_SW_TRIG};
        6'd22: step_entry = {2'd0, `SCS_A_LPF,       `SCS_V_LPF};
        default: step_entry = {2'd2, `SCS_A_AFILT,   `SCS_V_AFILT};
      endcase
    end
  endfunction
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [4:0]  state_ff;
  reg  [5:0]  step_ff;
  reg  [4:0]  bit_ff;
  reg  [23:0] shreg_ff;
  reg  [2:0]  div_ff;
  reg  [19:0] wait_ff;
  reg  [9:0]  tune_ff;
  reg  [2:0]  adc_sync_ff;
  reg         hw_trig_ff;
  reg         err_ff;
  wire [22:0] entry;
  wire        tick;
  wire        adc_rise;
  wire        apb_wr;
  wire        busy;
  assign entry   = step_entry(step_ff);
  assign tick    = (div_ff == SCLK_DIV[2:0] - 3'd1);
  assign busy    = ~state_ff[0] & ~state_ff[4];
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel & penable & pwrite;
  // The ADC clock is asynchronous: two flops first, edge detect on the third.
  assign adc_rise = adc_sync_ff[1] & ~adc_sync_ff[2];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_sync_ff <= 3'b000;
    end else begin
      adc_sync_ff <= {adc_sync_ff[1:0], adc_clk};
    end
  end
  // Serial clock divider; sclk toggles on each tick while shifting, giving 2*SCLK_DIV cycles per period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 3'd0;
    end else if (tick || !busy) begin
      div_ff <= 3'd0;
    end else begin
      div_ff <= div_ff + 3'd1;
    end
  end
  // ****************************************************************
  // Software registers: read decode.
  // ****************************************************************
  always @* begin
    if (paddr == `SCS_R_CTRL) begin
      prdata = {30'd0, hw_trig_ff, 1'b0};
    end else if (paddr == `SCS_R_STATUS) begin
      prdata = {19'd0, step_ff, err_ff, 2'd0, state_ff[4], busy, sdio_in & 1'b0, 1'b0};
    end else if (paddr == `SCS_R_WAKE) begin
      prdata = {12'd0, wait_ff};
    end else if (paddr == `SCS_R_TUNE) begin
      prdata = {22'd0, tune_ff};
    end else begin
      prdata = 32'h0000_0000;
    end
  end
  // ****************************************************************
  // Sequencer: one full single-byte write frame per table step.
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff                  <= ST_IDLE;
      step_ff                   <= 6'd0;
      bit_ff                    <= 5'd0;
      shreg_ff                  <= 24'd0;
      wait_ff                   <= 20'd0;
      tune_ff                   <= 10'd0;
      hw_trig_ff                <= 1'b0;
      err_ff                    <= 1'b0;
      sclk_ff                   <= 1'b0;
      select_bar_ff             <= 1'b1;
      sdio_out_ff               <= 1'b0;
      sdio_oe_ff                <= 1'b0;
      transmit_trigger_input_ff <= 1'b0;
    end else begin
      if (apb_wr && paddr == `SCS_R_CTRL) begin
        hw_trig_ff <= pwdata[`SCS_CTRL_HWTRIG];
      end
      // The trigger line is held high once done when selected; the software trigger write still goes out.
      transmit_trigger_input_ff <= hw_trig_ff & state_ff[4];
      case (state_ff)
        ST_IDLE: begin
          if (apb_wr && paddr == `SCS_R_CTRL && pwdata[`SCS_CTRL_START]) begin
            step_ff  <= 6'd0;
            err_ff   <= 1'b0;
            state_ff <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Chip select high between frames; load next write, MSB first.
          if (tick) begin
            shreg_ff      <= {1'b0, 2'b00, entry[20:8], entry[7:0]};
            bit_ff        <= 5'd0;
            select_bar_ff <= 1'b0;
            sdio_oe_ff    <= 1'b1;
            sdio_out_ff   <= 1'b0;
            state_ff      <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // Data changes on falling sclk, device samples on rising sclk.
          if (tick) begin
            sclk_ff <= ~sclk_ff;
            if (sclk_ff) begin
              if (bit_ff == 5'd23) begin
                // Frame ends on a byte boundary so the device never resets mid-byte.
                select_bar_ff <= 1'b1;
                sdio_oe_ff    <= 1'b0;
                if (entry[22:21] == 2'd1) begin
                  wait_ff  <= WAKE_CYC[19:0];
                  state_ff <= ST_WAIT;
                end else if (entry[22:21] == 2'd2) begin
                  // Two idle cycles drain a sample-clock edge already in the synchroniser,
                  // so an edge from before the write is never counted as a tuning cycle.
                  tune_ff  <= `SCS_TUNE_ADC_CYC;
                  wait_ff  <= 20'd2;
                  state_ff <= ST_WAIT;
                end else begin
                  step_ff  <= step_ff + 6'd1;
                  state_ff <= ST_GAP;
                end
              end else begin
                // The next bit goes out with the falling edge, a full half period before the rise.
                bit_ff      <= bit_ff + 5'd1;
                shreg_ff    <= {shreg_ff[22:0], 1'b0};
                sdio_out_ff <= shreg_ff[22];
              end
            end
          end
        end
        ST_WAIT: begin
          // Wake-up and filter tuning intervals hold back the next frame.
          if (wait_ff != 20'd0) begin
            wait_ff <= wait_ff - 20'd1;
          end else if (tune_ff != 10'd0) begin
            if (adc_rise) begin
              tune_ff <= tune_ff - 10'd1;
            end
          end else if (step_ff == `SCS_STEPS - 6'd4) begin
            state_ff <= ST_DONE;
          end else begin
            step_ff  <= step_ff + 6'd1;
            state_ff <= ST_GAP;
          end
        end
        ST_DONE: begin
          if (apb_wr && paddr == `SCS_R_CTRL && pwdata[`SCS_CTRL_START]) begin
            step_ff  <= 6'd0;
            state_ff <= ST_GAP;
          end
        end
        default: begin
          err_ff   <= 1'b1;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/scs_seq_props.sv
// Checker of the serial port and APB answers of the sequencer.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module scs_seq_props (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial port and trigger.
  input wire logic        sclk_ff,
  input wire logic        select_bar_ff,
  input wire logic        sdio_out_ff,
  input wire logic        sdio_oe_ff,
  input wire logic        transmit_trigger_input_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] bit_cnt_ff;
  // Clock rises of the frame; restarts whenever select is high.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bit_cnt_ff <= 6'd0;
    else if (select_bar_ff)
      bit_cnt_ff <= 6'd0;
    else if ($rose(sclk_ff))
      bit_cnt_ff <= bit_cnt_ff + 6'd1;
  end
  sequence s_high_phase;
    sclk_ff [*5] ##1 !sclk_ff;
  endsequence
  sequence s_gap;
    select_bar_ff [*5];
  endsequence
  a_idle_clock: assert property (select_bar_ff |-> !sclk_ff) else $error("clock moves outside frame");
  a_frame_drive: assert property (!select_bar_ff |-> sdio_oe_ff) else $error("data not driven in frame");
  a_clock_high: assert property ($rose(sclk_ff) |-> s_high_phase) else $error("clock high phase wrong");
  a_data_hold: assert property (sclk_ff |-> $stable(sdio_out_ff)) else $error("data moved while clock high");
  a_frame_bits: assert property ($rose(select_bar_ff) |-> bit_cnt_ff == 6'd24) else $error("frame not 24 bits");
  a_write_one: assert property ($rose(sclk_ff) && bit_cnt_ff < 6'd3 |-> !sdio_out_ff) else $error("not a one byte write");
  a_frame_gap: assert property ($rose(select_bar_ff) |-> s_gap) else $error("frames too close");
  a_apb_answer: assert property (psel |-> pready && !pslverr) else $error("apb answer wrong");
  a_unmapped_zero: assert property (psel && !pwrite && paddr[11:4] != 8'h00 |-> prdata == 32'h0) else $error("unmapped read");
  a_trig_quiet: assert property (!select_bar_ff |-> !transmit_trigger_input_ff) else $error("trigger during load");
endmodule
bind scs_startup_config_sequencer scs_seq_props i_scs_seq_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_ff(sclk_ff),
  .select_bar_ff(select_bar_ff), .sdio_out_ff(sdio_out_ff), .sdio_oe_ff(sdio_oe_ff),
  .transmit_trigger_input_ff(transmit_trigger_input_ff));
`default_nettype wire

// ===== verif/scs_dev_model.sv
// Behavioural model of the front end's serial control port.
`timescale 1ns/1ps
`default_nettype none
module scs_dev_model (
  // Serial port from the host.
  input wire logic        sclk,
  input wire logic        select_bar,
  input wire logic        sdio,
  // Observed state.
  output var logic [23:0] word,
  output var logic [5:0]  bits,
  output var logic [7:0]  frames,
  output var logic [7:0]  cfg,
  output var logic        pwr_dn
);
  logic [23:0] sh;
  logic [5:0]  nb;
  // Power-on state: fully powered down, port config at its default.
  initial begin
    pwr_dn = 1'b1;
    cfg = 8'h18;
    frames = 8'd0;
    nb = 6'd0;
  end
  // Data is taken at each clock rise while selected, first bit first.
  always @(posedge sclk) begin
    if (!select_bar) begin
      sh = {sh[22:0], sdio};
      nb = nb + 6'd1;
    end
  end
  // Select high ends the frame and rearms the port, even mid-byte.
  always @(posedge select_bar) begin
    if (nb != 6'd0) begin
      word <= sh;
      bits <= nb;
      frames <= frames + 8'd1;
      if (nb == 6'd24 && sh[20:8] == 13'h000)
        cfg <= 8'h18 | ((sh[5] | sh[2]) ? 8'h00 : sh[7:0] & 8'h42);
      if (nb == 6'd24 && sh[20:8] == 13'h008)
        pwr_dn <= sh[2:0] != 3'b000;
    end
    nb = 6'd0;
  end
endmodule
`default_nettype wire

// ===== verif/test_scs_startup_config_sequencer.sv
// Self-checking bench of the start-up sequencer against a device model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end end
module test_scs_startup_config_sequencer;
  logic        pclk, presetn, psel, penable, pwrite, adc_clk, hw;
  logic [11:0] paddr, ua;
  logic [31:0] pwdata, q, r;
  wire  [31:0] prdata;
  wire         pready, pslverr, sclk, sel_n, sdo, sdoe, trig;
  wire  [23:0] word;
  wire  [5:0]  bits;
  wire  [7:0]  frames, cfg;
  wire         pwr_dn;
  integer      mismatches, compares, seed, k, cyc, t13, adcn;
  // Released data line shows the inverse of the last bit.
  wire         sdio = sdoe ? sdo : ~sdo;
  logic [23:0] tbl [0:23] = '{24'h00003c, 24'h000200, 24'h00ff01, 24'h00040f, 24'h00053f, 24'h011300,
    24'h001106, 24'h0f00ff, 24'h0f017f, 24'h0f0200, 24'h0f0380, 24'h010c00, 24'h001400, 24'h000800,
    24'h002105, 24'h019980, 24'h019b50, 24'h018801, 24'h018b27, 24'h018c72, 24'h018282, 24'h010c20,
    24'h000f18, 24'h002b40};
  scs_startup_config_sequencer #(.WAKE_CYC(50), .SCLK_DIV(5)) i_scs_startup_config_sequencer (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_clk(adc_clk), .sclk_ff(sclk),
    .select_bar_ff(sel_n), .sdio_out_ff(sdo), .sdio_oe_ff(sdoe), .sdio_in(sdio), .transmit_trigger_input_ff(trig));
  scs_dev_model i_scs_dev_model (.sclk(sclk), .select_bar(sel_n), .sdio(sdio), .word(word), .bits(bits),
    .frames(frames), .cfg(cfg), .pwr_dn(pwr_dn));
  // Clocks; the sample clock has its own unrelated phase.
  always #2 pclk = ~pclk;
  always #40 adc_clk = ~adc_clk;
  always @(posedge pclk) cyc++;
  always @(posedge adc_clk) adcn++;
  task test_done;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk) penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (k >= 50) begin mismatches++; test_done; end
    end
  endtask
  // Every finished frame is compared with the start-up table.
  always @(frames) begin
    if (frames != 8'd0) begin
      `CHK("frame", tbl[frames-8'd1], word)
      `CHK("bits", 6'd24, bits)
      if (frames == 8'd15) `CHK("wake", 1'b1, cyc - t13 >= 290)
      if (frames == 8'd14) t13 = cyc;
      if (frames == 8'd24) adcn = 0;
    end
  end
  initial begin
    seed = 32'h2212; mismatches = 0; compares = 0; cyc = 0; adcn = 0; t13 = 0;
    pclk = 0; adc_clk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    r = $random(seed);
    hw = r[0];
    ua = {r[11:4] | 8'h01, 4'h0};
    apb(1'b1, ua, r);
    apb(1'b0, ua, 32'h0);
    `CHK("unmapped", 32'h0, q)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("idle", 2'b00, {q[3], q[2]})
    apb(1'b1, 12'h000, {30'h0, hw, 1'b1});
    apb(1'b0, 12'h004, 32'h0);
    `CHK("busy", 1'b1, q[2])
    // A second start while busy must not restart the load.
    apb(1'b1, 12'h000, {30'h0, hw, 1'b1});
    k = 0;
    do begin apb(1'b0, 12'h004, 32'h0); k++; end while (q[3] !== 1'b1 && k < 10000);
    if (k >= 10000) begin mismatches++; test_done; end
    `CHK("tune", 1'b1, adcn >= 512 && adcn <= 514)
    `CHK("status", 2'b00, {q[6], q[2]})
    `CHK("frames", 8'd24, frames)
    `CHK("cfg", 8'h18, cfg)
    `CHK("power", 1'b0, pwr_dn)
    `CHK("trig", hw, trig)
    apb(1'b1, 12'h000, {30'h0, ~hw, 1'b0});
    repeat (3) @(posedge pclk);
    `CHK("trig", ~hw, trig)
    test_done;
  end
endmodule
`default_nettype wire
